// ===== verilog/bb_timer_pkg.sv
package bb_timer_pkg;

	// ----------------------------------------
	// register map (word index; byte address is four times the index)
	// ----------------------------------------
	localparam logic [15:0] IDX_TIMEOUT_LOW = 16'h413E;
	localparam logic [15:0] IDX_TIMEOUT_HIGH = 16'h413F;
	localparam logic [15:0] IDX_DESC_VERSION = 16'h4140;
	localparam logic [15:0] IDX_DESC_STRINGS = 16'h4141;
	localparam logic [15:0] IDX_STATUS = 16'h4142;
	localparam int IDX_LSB = 2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int STAT_RUNNING_BIT = 0;
	localparam int STAT_DETACHED_BIT = 1;
	localparam int STAT_BILLBOARD_BIT = 2;
	localparam logic [7:0] TIMEOUT_LOW_RST = 8'hD0;
	localparam logic [7:0] TIMEOUT_HIGH_RST = 8'h07;
	localparam logic [7:0] VERSION_LOW_RST = 8'h10;
	localparam logic [7:0] VERSION_HIGH_RST = 8'h01;
	localparam logic [7:0] FAIL_INFO_RST = 8'h00;
	localparam logic [7:0] RESERVED_RST = 8'h00;
	localparam logic [7:0] ALT_STRING_IDX_RST = 8'h00;
	localparam logic [7:0] URL_IDX_RST = 8'h01;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int STEP_MS = 10;
	localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
	localparam int DETACH_MS = 2;
	localparam int DETACH_CYCLES = CLK_HZ / 1000 * DETACH_MS;

	typedef struct packed {
		logic [7:0] reserved_byte;
		logic [7:0] extra_failure_info_byte;
		logic [15:0] descriptor_version_field;
	} desc_version_type;

	typedef struct packed {
		logic attach_n;
		logic billboard_mode;
	} port_ctl_type;

endpackage

// ===== verilog/step_tick.sv
`timescale 1ns/100ps
module step_tick #(
	parameter int STEP = 250000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic restart,
	output logic tick
);
	logic [31:0] cnt_r;

	// ----------------------------------------
	// prescaler: one pulse every STEP cycles
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
		end else if (restart || cnt_r == 32'(STEP - 1)) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
	assign tick = !restart && cnt_r == 32'(STEP - 1);
endmodule // step_tick

// ===== verilog/billboard_detach_timer.sv
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
module billboard_detach_timer #(
	parameter int STEP_CYC = bb_timer_pkg::STEP_CYCLES,
	parameter int DETACH_CYC = bb_timer_pkg::DETACH_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic billboard_active,
	input wire logic alt_string_req,
	output bb_timer_pkg::port_ctl_type port_ctl
);
	import bb_timer_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN = 4'b0010,
		ST_DETACH = 4'b0100,
		ST_DONE = 4'b1000
	} state_type;

	state_type state_r;
	logic [7:0] tmo_low_r;
	logic [7:0] tmo_high_r;
	desc_version_type desc_r;
	logic [7:0] alt_idx_r;
	logic [7:0] url_idx_r;
	logic [7:0] tmo_low_nxt;
	logic [7:0] tmo_high_nxt;
	desc_version_type desc_nxt;
	logic [7:0] alt_idx_nxt;
	logic [7:0] url_idx_nxt;
	logic [15:0] remain_r;
	logic [31:0] det_cnt_r;
	logic wr_pend_r;
	logic [15:0] addr_r;
	logic [15:0] idx;
	logic idx_ok;
	logic xfer;
	logic tick;
	logic start;
	logic addr_ok;
	logic [31:0] rd_nxt;

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// registers are whole words: narrower transfers are dropped, never merged
	assign xfer = hready && hsel && htrans[1] && hsize == HSIZE_WORD;
	assign idx = haddr[IDX_LSB +: 16];
	// upper and byte-lane bits must be clear, or the map would alias
	assign idx_ok = haddr[31:IDX_LSB + 16] == '0 && haddr[IDX_LSB - 1:0] == '0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			addr_r <= 16'h0;
		end else if (hready) begin
			wr_pend_r <= xfer && hwrite && idx_ok;
			addr_r <= idx;
		end
	end

	// ----------------------------------------
	// register write path
	// ----------------------------------------
	// writes land through the _nxt values, so a read taken in the data
	// phase of a write to the same word already returns the new contents
	always_comb begin
		tmo_low_nxt = tmo_low_r;
		tmo_high_nxt = tmo_high_r;
		desc_nxt = desc_r;
		alt_idx_nxt = alt_idx_r;
		url_idx_nxt = url_idx_r;
		if (wr_pend_r && addr_r == IDX_TIMEOUT_LOW) begin
			tmo_low_nxt = hwdata[7:0];
		end
		if (wr_pend_r && addr_r == IDX_TIMEOUT_HIGH) begin
			tmo_high_nxt = hwdata[7:0];
		end
		if (wr_pend_r && addr_r == IDX_DESC_VERSION) begin
			desc_nxt = hwdata;
		end
		if (wr_pend_r && addr_r == IDX_DESC_STRINGS) begin
			alt_idx_nxt = hwdata[7:0];
			url_idx_nxt = hwdata[15:8];
		end
	end

	// read data sampled from the address phase so it stands in the data phase
	always_comb begin
		addr_ok = 1'b1;
		rd_nxt = 32'h0;
		unique case (idx)
			IDX_TIMEOUT_LOW: rd_nxt = {24'h0, tmo_low_nxt};
			IDX_TIMEOUT_HIGH: rd_nxt = {24'h0, tmo_high_nxt};
			IDX_DESC_VERSION: rd_nxt = desc_nxt;
			IDX_DESC_STRINGS: rd_nxt = {16'h0, url_idx_nxt, alt_idx_nxt};
			IDX_STATUS: begin
				rd_nxt[STAT_RUNNING_BIT] = state_r == ST_RUN;
				rd_nxt[STAT_DETACHED_BIT] = state_r == ST_DETACH;
				rd_nxt[STAT_BILLBOARD_BIT] = port_ctl.billboard_mode;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// unmapped or aliased reads return zero and leave no side effect
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0;
		end else if (xfer && !hwrite) begin
			hrdata <= (addr_ok && idx_ok) ? rd_nxt : 32'h0;
		end
	end

	// ----------------------------------------
	// timeout registers
	// ----------------------------------------
	// the pair only becomes a count when a request loads it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_low_r <= TIMEOUT_LOW_RST;
			tmo_high_r <= TIMEOUT_HIGH_RST;
		end else begin
			tmo_low_r <= tmo_low_nxt;
			tmo_high_r <= tmo_high_nxt;
		end
	end

	// ----------------------------------------
	// descriptor fields
	// ----------------------------------------
	// defaults hold until software rewrites them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_r <= {RESERVED_RST, FAIL_INFO_RST, VERSION_HIGH_RST, VERSION_LOW_RST};
			alt_idx_r <= ALT_STRING_IDX_RST;
			url_idx_r <= URL_IDX_RST;
		end else begin
			desc_r <= desc_nxt;
			alt_idx_r <= alt_idx_nxt;
			url_idx_r <= url_idx_nxt;
		end
	end

	// ----------------------------------------
	// 10 ms step counter and detach sequence
	// ----------------------------------------
	// a request during the disconnect is ignored: the host has lost the device
	assign start = alt_string_req && billboard_active && state_r != ST_DETACH;

	// restart lines the first step up with the request, so the span is exact
	step_tick #(
		.STEP(STEP_CYC)
	) step_tick_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.restart(start),
		.tick(tick)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			remain_r <= 16'h0;
			det_cnt_r <= 32'h0;
		end else begin
			unique case (state_r)
				ST_IDLE, ST_RUN, ST_DONE: begin
					if (start) begin
						state_r <= ST_RUN;
						remain_r <= {tmo_high_r, tmo_low_r};
					end else if (state_r == ST_RUN && tick) begin
						if (remain_r <= 16'h1) begin
							// zero count expires on the first step rather than never
							state_r <= ST_DETACH;
							remain_r <= 16'h0;
							det_cnt_r <= 32'h0;
						end else begin
							remain_r <= remain_r - 16'h1;
						end
					end
				end
				ST_DETACH: begin
					// long enough for the hub port to notice the disconnect
					if (det_cnt_r == 32'(DETACH_CYC - 1)) begin
						state_r <= ST_DONE;
					end else begin
						det_cnt_r <= det_cnt_r + 32'h1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// port control
	// ----------------------------------------
	// registered so the port never sees a decode glitch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_ctl <= '0;
		end else begin
			port_ctl.attach_n <= state_r == ST_DETACH;
			port_ctl.billboard_mode <= billboard_active && state_r != ST_DETACH
				&& state_r != ST_DONE;
		end
	end
endmodule // billboard_detach_timer

// ===== bench/bb_timer_properties.sv
`timescale 1ns/100ps
module bb_timer_chk #(
	parameter int STEP_CYC = 4,
	parameter int DETACH_CYC = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic billboard_active,
	input wire logic alt_string_req,
	input wire bb_timer_pkg::port_ctl_type port_ctl
);
	logic at;
	logic bm;
	assign at = port_ctl.attach_n;
	assign bm = port_ctl.billboard_mode;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_rdy; hreadyout; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state");
	property p_ok; !hresp; endproperty
	a_ok: assert property (p_ok) else $error("error reply");
	property p_start; alt_string_req && billboard_active && !at |=> !at[*3]; endproperty
	a_start: assert property (p_start) else $error("early detach");
	property p_len; $rose(at) |-> at[*3]; endproperty
	a_len: assert property (p_len) else $error("short detach");
	property p_end; $rose(at) |-> ##[3:5] !at; endproperty
	a_end: assert property (p_end) else $error("long detach");
	property p_cause; $rose(at) |-> $past(bm); endproperty
	a_cause: assert property (p_cause) else $error("stray detach");
	property p_std; $fell(at) |-> !bm; endproperty
	a_std: assert property (p_std) else $error("billboard kept");
	property p_stay; $fell(at) && !alt_string_req |=> !at; endproperty
	a_stay: assert property (p_stay) else $error("reattach lost");
endmodule // bb_timer_chk
bind billboard_detach_timer bb_timer_chk #(.STEP_CYC(STEP_CYC), .DETACH_CYC(DETACH_CYC)) bb_timer_chk_i (
	.ref_clk, .rst_n, .hreadyout, .hresp, .billboard_active, .alt_string_req, .port_ctl);

// ===== bench/host_model.sv
`timescale 1ns/100ps
module host_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic go,
	output logic billboard_active,
	output logic alt_string_req
);
	// enumerated once reset lifts; enable pin sequencing lives elsewhere
	assign billboard_active = rst_n;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_string_req <= 1'h0;
		end else begin
			alt_string_req <= go;
		end
	end
endmodule // host_model

// ===== bench/test_billboard_detach_timer.sv
`timescale 1ns/100ps
module test_billboard_detach_timer;
	import bb_timer_pkg::*;
	logic ref_clk = '0, rst_n = '0, hsel = '0, hwrite = '0, go = '0;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic hready, billboard_active, alt_string_req;
	port_ctl_type port_ctl;
	int err_total = 0, total_checks = 0, n;
	initial forever #20 ref_clk = ~ref_clk;
	billboard_detach_timer #(.STEP_CYC(4), .DETACH_CYC(3)) billboard_detach_timer_i (.ref_clk,
		.rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout(hready), .hresp(), .hrdata, .billboard_active, .alt_string_req, .port_ctl);
	host_model host_model_i (.ref_clk, .rst_n, .go, .billboard_active, .alt_string_req);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task pulse;
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
	endtask
	task wait_at(input logic lvl);
		n = 0;
		while (port_ctl.attach_n !== lvl && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task t_regs;
		bus(1'h1, 32'h10504, 32'h302);
		bus(1'h0, 32'h104F8, '0);
		chk(rd, 32'hD0);
		bus(1'h0, 32'h104FC, '0);
		chk(rd, 32'h7);
		bus(1'h0, 32'h10500, '0);
		chk(rd, 32'h110);
		bus(1'h0, 32'h10504, '0);
		chk(rd, 32'h302);
		bus(1'h0, 32'h10508, '0);
		chk(rd, 32'h4);
		bus(1'h0, 32'h4300, '0);
		chk(rd, '0);
		$display("t_regs end");
	endtask
	// a second request mid-count must restart the full span
	task t_expire;
		bus(1'h1, 32'h104F8, 32'h2);
		bus(1'h1, 32'h104FC, '0);
		pulse;
		repeat (2) @(posedge ref_clk);
		bus(1'h0, 32'h10508, '0);
		chk(rd, 32'h5);
		repeat (2) @(posedge ref_clk);
		chk(32'(port_ctl), 32'h1);
		pulse;
		wait_at(1'h1);
		chk(32'(n >= 8 && n <= 13), 32'h1);
		wait_at(1'h0);
		chk(32'(n >= 3 && n <= 5), 32'h1);
		chk(32'(port_ctl), '0);
		bus(1'h0, 32'h10508, '0);
		chk(rd, '0);
		$display("t_expire end");
	endtask
	// a zero count still expires, after one step
	task t_zero;
		bus(1'h1, 32'h104F8, '0);
		pulse;
		wait_at(1'h1);
		chk(32'(n >= 5 && n <= 9), 32'h1);
		bus(1'h0, 32'h10508, '0);
		chk(rd, 32'h2);
		$display("t_zero end");
	endtask
	task t_high;
		bus(1'h0, 32'h104F8, '0);
		chk(rd, 32'hD0);
		bus(1'h1, 32'h104FC, 32'h1);
		bus(1'h1, 32'h104F8, '0);
		bus(1'h0, 32'h104FC, '0);
		chk(rd, 32'h1);
		pulse;
		wait_at(1'h1);
		chk(32'(n >= 1023 && n <= 1029), 32'h1);
		$display("t_high end");
	endtask
	task test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_regs;
		t_expire;
		t_zero;
		rst_n <= 1'h0;
		@(posedge ref_clk);
		rst_n <= 1'h1;
		t_high;
		test_done;
	end
endmodule // test_billboard_detach_timer
